// ==== include/csm_pkg.sv ====
/*
 constants for the channel slot map block: register indices, field
 positions, reset values and widths shared by the rtl files.
 assumes an axi4-lite master addresses one 32-bit word per register.
*/
`default_nettype none
package csm_pkg;
   localparam int CSM_CHANS  = 3;   // third, fourth, fifth channel
   localparam int SLOT_W     = 6;   // slot field width
   localparam int BIT_W      = 5;   // bit position in a 32-bit slot
   localparam int SAMPLE_W   = 32;  // sample word width
   localparam int CHID_W     = 2;   // channel tag on the sample port
   localparam int FIFO_DEPTH = 4;   // sample fifo depth
   localparam int ADDR_W     = 12;  // axi byte address width
   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_CHAN3 = 8'h0D;
   localparam logic [7:0] IDX_CHAN4 = 8'h0E;
   localparam logic [7:0] IDX_CHAN5 = 8'h0F;
   localparam logic [7:0] IDX_CTRL  = 8'h20;
   localparam logic [7:0] IDX_STAT  = 8'h21;
   localparam logic [2:0][7:0] CHAN_IDX = {IDX_CHAN5, IDX_CHAN4,
                                           IDX_CHAN3};
   // slot config fields
   localparam int LINE_BIT = 6;     // output line select
   localparam int SLOT_LSB = 0;     // slot field low bit
   localparam logic [7:0] CFG_MASK  = 8'h7F;  // bit 7 reserved
   localparam logic [7:0] CHAN3_RST = 8'h02;
   localparam logic [7:0] CHAN4_RST = 8'h03;
   localparam logic [7:0] CHAN5_RST = 8'h04;
   localparam logic [2:0][7:0] CHAN_RST = {CHAN5_RST, CHAN4_RST,
                                           CHAN3_RST};
   // control fields
   localparam int CTRL_EN_BIT   = 0; // serial output enable
   localparam int CTRL_HALF_BIT = 1; // 1 = i2s or left justified
   localparam logic [7:0] CTRL_MASK = 8'h03;
   localparam logic [7:0] CTRL_RST  = 8'h00;
   // status fields
   localparam int STAT_FIFO_BIT = 0;  // fifo holds a sample
   localparam int STAT_LOAD_LSB = 1;  // three loaded flags
   localparam int STAT_POS_LSB  = 8;  // current slot position
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : csm_pkg
`default_nettype wire

// ==== rtl/csm_fifo.sv ====
/*
 small synchronous fifo with valid and ready on both sides.
 assumes depth is a power of two and one clock for both sides.
*/
`default_nettype none
module csm_fifo #(
   parameter int WIDTH = 34,
   parameter int DEPTH = 4
) (
   input  wire logic             sys_clk_in,
   input  wire logic             rst_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int PW = $clog2(DEPTH);
   localparam logic [PW:0] FULL = (PW+1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];             // storage flops
   logic [PW-1:0]    wr_ptr, next_wr_ptr;     // write pointer
   logic [PW-1:0]    rd_ptr, next_rd_ptr;     // read pointer
   logic [PW:0]      count,  next_count;      // words held
   logic             push, pop;               // transfers this cycle

   // honest full and empty from the word count
   assign in_ready_out  = (count != FULL);
   assign out_valid_out = (count != '0);
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_valid_out & out_ready_in;
   assign out_data_out  = mem[rd_ptr];

   // pointer and count updates
   always_comb begin
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count  = count + (PW+1)'(push) - (PW+1)'(pop);
   end

   // register pointers, reset empties the fifo
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count  <= next_count;
      end
   end

   // data store needs no reset, count guards it
   always_ff @(posedge sys_clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end
endmodule : csm_fifo
`default_nettype wire

// ==== rtl/csm_top.sv ====
/*
 slot mapper for three record channels: axi4-lite register file,
 sample fifo, per-channel holding words and serial slot drivers.
 assumes bit_tick_in pulses once per serial bit and frame_clk_in is
 the frame clock level, both synchronous to sys_clk_in.
*/
// The AXI4-Lite slave port was chosen for this implementation.
`default_nettype none
module csm_top
   import csm_pkg::*;
(
   input  wire logic                sys_clk_in,
   input  wire logic                rst_in,
   input  wire logic [ADDR_W-1:0]   awaddr_in,
   input  wire logic                awvalid_in,
   output logic                     awready_out,
   input  wire logic [31:0]         wdata_in,
   input  wire logic [3:0]          wstrb_in,
   input  wire logic                wvalid_in,
   output logic                     wready_out,
   output logic      [1:0]          bresp_out,
   output logic                     bvalid_out,
   input  wire logic                bready_in,
   input  wire logic [ADDR_W-1:0]   araddr_in,
   input  wire logic                arvalid_in,
   output logic                     arready_out,
   output logic      [31:0]         rdata_out,
   output logic      [1:0]          rresp_out,
   output logic                     rvalid_out,
   input  wire logic                rready_in,
   input  wire logic [SAMPLE_W-1:0] sample_data_in,
   input  wire logic [CHID_W-1:0]   sample_chan_in,
   input  wire logic                sample_valid_in,
   output logic                     sample_ready_out,
   input  wire logic                bit_tick_in,
   input  wire logic                frame_clk_in,
   output logic                     primary_serial_out_pin_out,
   output logic                     primary_serial_out_pin_oe_out,
   output logic                     general_pin_one_out,
   output logic                     general_pin_one_oe_out
);
   localparam int FW = SAMPLE_W + CHID_W;   // fifo word width

   // register file state
   logic [2:0][7:0]  cfg, next_cfg;         // slot config per channel
   logic [7:0]       ctrl, next_ctrl;       // enable and format
   // write channel state
   logic             aw_full, next_aw_full; // address held
   logic [7:0]       aw_idx, next_aw_idx;   // held word index
   logic             w_full, next_w_full;   // data held
   logic [7:0]       w_data, next_w_data;   // held low byte
   logic             w_strb, next_w_strb;   // held lane 0 strobe
   logic             bvalid, next_bvalid;
   logic [1:0]       bresp, next_bresp;
   // read channel state
   logic             rvalid, next_rvalid;
   logic [31:0]      rdata, next_rdata;
   logic [1:0]       rresp, next_rresp;
   // serial state
   logic             frame_prev, next_frame_prev;
   logic [SLOT_W-1:0] slot_pos, next_slot_pos; // next slot position
   logic [BIT_W-1:0] bit_pos, next_bit_pos;    // next bit in slot
   logic [2:0]       loaded, next_loaded;      // holding word valid
   logic [2:0][SAMPLE_W-1:0] hold, next_hold;  // holding words
   logic             pri_out, next_pri_out;
   logic             pri_oe, next_pri_oe;
   logic             gen_out, next_gen_out;
   logic             gen_oe, next_gen_oe;
   // combinational helpers
   logic             aw_take, w_take, do_write, ar_take;
   logic [7:0]       wr_idx;                // index of the write
   logic [7:0]       ar_idx;                // index of the read
   logic             en, half, rise, restart;
   logic [BIT_W-1:0] cur_bit;               // bit on the wire now
   logic [SLOT_W-1:0] cur_pos;              // slot on the wire now
   logic [2:0]       own, line_sel, bitv;   // per channel
   logic             fifo_valid, fifo_ready;
   logic [FW-1:0]    fifo_data;
   logic [CHID_W-1:0] fifo_ch;

   // samples pass a fifo so the source stalls only while the fifo is full
   csm_fifo #(
      .WIDTH (FW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .sys_clk_in    (sys_clk_in),
      .rst_in        (rst_in),
      .in_valid_in   (sample_valid_in),
      .in_ready_out  (sample_ready_out),
      .in_data_in    ({sample_chan_in, sample_data_in}),
      .out_valid_out (fifo_valid),
      .out_ready_in  (fifo_ready),
      .out_data_out  (fifo_data)
   );
   assign fifo_ch = fifo_data[FW-1 -: CHID_W];

   // axi handshakes, one write and one read in flight
   assign awready_out = !aw_full && !bvalid;
   assign wready_out  = !w_full && !bvalid;
   assign arready_out = !rvalid;
   assign aw_take     = awvalid_in && awready_out;
   assign w_take      = wvalid_in && wready_out;
   assign ar_take     = arvalid_in && arready_out;
   assign wr_idx      = aw_take ? awaddr_in[9:2] : aw_idx;
   assign ar_idx      = araddr_in[9:2];
   assign do_write    = (aw_full || aw_take) && (w_full || w_take);
   assign bvalid_out  = bvalid;
   assign bresp_out   = bresp;
   assign rvalid_out  = rvalid;
   assign rdata_out   = rdata;
   assign rresp_out   = rresp;

   // bus and register next state
   always_comb begin
      logic [7:0] wd;
      logic       ws;
      logic       hit;
      wd           = w_take ? wdata_in[7:0] : w_data;
      ws           = w_take ? wstrb_in[0] : w_strb;
      hit          = 1'b0;
      next_cfg     = cfg;
      next_ctrl    = ctrl;
      next_aw_full = aw_full || aw_take;
      next_aw_idx  = aw_take ? awaddr_in[9:2] : aw_idx;
      next_w_full  = w_full || w_take;
      next_w_data  = wd;
      next_w_strb  = ws;
      next_bvalid  = bvalid && !bready_in;
      next_bresp   = bresp;
      next_rvalid  = rvalid && !rready_in;
      next_rdata   = rdata;
      next_rresp   = rresp;
      if (do_write) begin
         // both halves present: commit and answer
         next_aw_full = 1'b0;
         next_w_full  = 1'b0;
         next_bvalid  = 1'b1;
         for (int i = 0; i < CSM_CHANS; i++) begin
            if (wr_idx == CHAN_IDX[i]) begin
               hit = 1'b1;
               if (ws) begin
                  next_cfg[i] = wd & CFG_MASK;
               end
            end
         end
         if (wr_idx == IDX_CTRL) begin
            hit = 1'b1;
            if (ws) begin
               next_ctrl = wd & CTRL_MASK;
            end
         end
         // status takes writes silently
         if (wr_idx == IDX_STAT) begin
            hit = 1'b1;
         end
         next_bresp = hit ? RESP_OKAY : RESP_SLVERR;
      end
      if (ar_take) begin
         next_rvalid = 1'b1;
         next_rdata  = '0;
         next_rresp  = RESP_OKAY;
         if (ar_idx == IDX_CHAN3) begin
            next_rdata[7:0] = cfg[0];
         end else if (ar_idx == IDX_CHAN4) begin
            next_rdata[7:0] = cfg[1];
         end else if (ar_idx == IDX_CHAN5) begin
            next_rdata[7:0] = cfg[2];
         end else if (ar_idx == IDX_CTRL) begin
            next_rdata[7:0] = ctrl;
         end else if (ar_idx == IDX_STAT) begin
            // live state: fifo, holds and slot on the wire
            next_rdata[STAT_FIFO_BIT] = fifo_valid;
            next_rdata[STAT_LOAD_LSB +: 3] = loaded;
            next_rdata[STAT_POS_LSB +: SLOT_W] = cur_pos;
         end else begin
            next_rresp = RESP_SLVERR;    // unmapped word
         end
      end
   end

   // register the bus and register file
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         cfg     <= CHAN_RST;
         ctrl    <= CTRL_RST;
         aw_full <= 1'b0;
         aw_idx  <= '0;
         w_full  <= 1'b0;
         w_data  <= '0;
         w_strb  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= RESP_OKAY;
      end else begin
         cfg     <= next_cfg;
         ctrl    <= next_ctrl;
         aw_full <= next_aw_full;
         aw_idx  <= next_aw_idx;
         w_full  <= next_w_full;
         w_data  <= next_w_data;
         w_strb  <= next_w_strb;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
         rvalid  <= next_rvalid;
         rdata   <= next_rdata;
         rresp   <= next_rresp;
      end
   end

   // frame position: tdm restarts on the rising frame edge, half
   // frame formats restart on either edge and take the half from
   // the frame clock level
   assign en      = ctrl[CTRL_EN_BIT];
   assign half    = ctrl[CTRL_HALF_BIT];
   assign rise    = frame_clk_in && !frame_prev;
   assign restart = half ? (frame_clk_in ^ frame_prev) : rise;
   assign cur_bit = restart ? '0 : bit_pos;
   assign cur_pos = half ? {frame_clk_in,
                            restart ? 5'h00 : slot_pos[4:0]}
                         : (restart ? '0 : slot_pos);

   // per channel slot match and msb-first bit pick
   for (genvar i = 0; i < CSM_CHANS; i++) begin : g_chan
      assign line_sel[i] = cfg[i][LINE_BIT];
      assign own[i]  = en &&
         (cfg[i][SLOT_LSB +: SLOT_W] == cur_pos);
      assign bitv[i] = loaded[i] && hold[i][~cur_bit];
   end

   // only an empty hold accepts, a bad tag is dropped
   assign fifo_ready = (fifo_ch == 2'h3) || !loaded[fifo_ch];

   // serial next state
   always_comb begin
      next_frame_prev = frame_clk_in;
      next_slot_pos   = slot_pos;
      next_bit_pos    = bit_pos;
      next_loaded     = loaded;
      next_hold       = hold;
      next_pri_out    = pri_out;
      next_pri_oe     = pri_oe;
      next_gen_out    = gen_out;
      next_gen_oe     = gen_oe;
      if (!en) begin
         // stopped: lines released, count parked
         next_slot_pos = '0;
         next_bit_pos  = '0;
         next_pri_oe   = 1'b0;
         next_gen_oe   = 1'b0;
         next_pri_out  = 1'b0;
         next_gen_out  = 1'b0;
      end else if (bit_tick_in) begin
         // overlapping owners on one line are or-ed together
         next_pri_oe  = |(own & ~line_sel);
         next_pri_out = |(own & ~line_sel & bitv);
         next_gen_oe  = |(own & line_sel);
         next_gen_out = |(own & line_sel & bitv);
         next_bit_pos = cur_bit + 1'b1;
         next_slot_pos = cur_pos;
         if (cur_bit == 5'h1F) begin
            if (half) begin
               next_slot_pos[4:0] = cur_pos[4:0] + 1'b1;
            end else begin
               next_slot_pos = cur_pos + 1'b1;
            end
            // a word is spent once its slot ends
            next_loaded = loaded & ~own;
         end
      end
      if (fifo_valid && fifo_ready && fifo_ch != 2'h3) begin
         next_loaded[fifo_ch] = 1'b1;
         next_hold[fifo_ch]   = fifo_data[SAMPLE_W-1:0];
      end
   end

   // register the serial side
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         frame_prev <= 1'b0;
         slot_pos   <= '0;
         bit_pos    <= '0;
         loaded     <= '0;
         hold       <= '0;
         pri_out    <= 1'b0;
         pri_oe     <= 1'b0;
         gen_out    <= 1'b0;
         gen_oe     <= 1'b0;
      end else begin
         frame_prev <= next_frame_prev;
         slot_pos   <= next_slot_pos;
         bit_pos    <= next_bit_pos;
         loaded     <= next_loaded;
         hold       <= next_hold;
         pri_out    <= next_pri_out;
         pri_oe     <= next_pri_oe;
         gen_out    <= next_gen_out;
         gen_oe     <= next_gen_oe;
      end
   end

   assign primary_serial_out_pin_out    = pri_out;
   assign primary_serial_out_pin_oe_out = pri_oe;
   assign general_pin_one_out           = gen_out;
   assign general_pin_one_oe_out        = gen_oe;

   // checks on the driven side
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);

   sequence s_wr_req;
      awvalid_in && awready_out && wvalid_in && wready_out;
   endsequence
   sequence s_last_bit;
      en && bit_tick_in && own[0] && cur_bit == 5'h1F;
   endsequence

   property p_line_pri;
      bit_tick_in && |(own & ~line_sel) |=> pri_oe && !gen_oe ||
         pri_oe && $past(|(own & line_sel));
   endproperty
   a_line_pri : assert property (p_line_pri)
      else $error("primary line not driven for its owner");

   property p_line_gen;
      bit_tick_in && |(own & line_sel) |=> gen_oe;
   endproperty
   a_line_gen : assert property (p_line_gen)
      else $error("secondary line not driven for its owner");

   property p_tdm_start;
      en && !half && bit_tick_in && rise |=>
         slot_pos == 6'h00 && bit_pos == 5'h01;
   endproperty
   a_tdm_start : assert property (p_tdm_start)
      else $error("tdm frame did not restart at slot 0");

   property p_tdm_wrap;
      en && !half && bit_tick_in && !restart &&
         slot_pos == 6'h3E && bit_pos == 5'h1F |=>
         slot_pos == 6'h3F && bit_pos == 5'h00;
   endproperty
   a_tdm_wrap : assert property (p_tdm_wrap)
      else $error("tdm slot 62 did not step to 63");

   // a half frame restart must land on slot 0 of the half that the
   // frame clock level names, not just copy the level through
   property p_half_pos;
      en && half && bit_tick_in && restart |=>
         slot_pos == {$past(frame_clk_in), 5'h00} && bit_pos == 5'h01;
   endproperty
   a_half_pos : assert property (p_half_pos)
      else $error("half frame slot in wrong half");

   // the first bit of a slot owned by the fourth channel must leave the
   // counter on the slot that its code asked for
   property p_own;
      bit_tick_in && own[1] && cur_bit == 5'h00 |=>
         bit_pos == 5'h01 && slot_pos == $past(cfg[1][5:0]);
   endproperty
   a_own : assert property (p_own)
      else $error("channel owns a slot other than its code");

   property p_rst4;
      $fell(rst_in) |-> cfg[1] == CHAN4_RST;
   endproperty
   a_rst4 : assert property (p_rst4)
      else $error("fourth channel reset value wrong");

   property p_rst5;
      $fell(rst_in) |-> cfg[2] == CHAN5_RST;
   endproperty
   a_rst5 : assert property (p_rst5)
      else $error("fifth channel reset value wrong");

   property p_rst3;
      $fell(rst_in) |-> cfg[0] == CHAN3_RST;
   endproperty
   a_rst3 : assert property (p_rst3)
      else $error("third channel reset value wrong");

   property p_idle;
      bit_tick_in && own == 3'h0 |=> !pri_oe && !gen_oe;
   endproperty
   a_idle : assert property (p_idle)
      else $error("line driven in an unowned slot");

   property p_hold;
      !bit_tick_in && en |=> $stable(pri_out) && $stable(pri_oe);
   endproperty
   a_hold : assert property (p_hold)
      else $error("primary line moved without a bit tick");

   property p_consume;
      s_last_bit |=> !loaded[0];
   endproperty
   a_consume : assert property (p_consume)
      else $error("sample word not spent at slot end");

   property p_wr_resp;
      s_wr_req |=> bvalid_out ##0 !awready_out;
   endproperty
   a_wr_resp : assert property (p_wr_resp)
      else $error("write not answered next cycle");
endmodule : csm_top
`default_nettype wire

// ==== verification/csm_host_model.sv ====
/*
 receiving host model: makes bit ticks and the frame clock, and
 captures both serial lines into one word per slot position.
 assumes the slot mapper updates its pins one cycle after a tick.
*/
`default_nettype none
module csm_host_model (
   input  wire logic       sys_clk_in,
   input  wire logic       rst_in,
   input  wire logic       run_in,     // frames run while high
   input  wire logic       half_in,    // half-frame formats
   input  wire logic [3:0] gap_in,     // cycles per tick, at least 4
   input  wire logic       pri_in,
   input  wire logic       pri_oe_in,
   input  wire logic       sec_in,
   input  wire logic       sec_oe_in,
   output logic            bit_tick_out,
   output logic            frame_clk_out,
   output logic [7:0]      frames_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0]  cnt;              // cycles within one tick
   logic [10:0] pos;              // next bit position in frame
   logic [10:0] cur;              // position being captured
   logic [31:0] pri_word [64];    // primary line, per slot
   logic [31:0] sec_word [64];    // secondary line, per slot
   int          pri_ones;         // driven bits seen on primary
   int          sec_ones;         // driven bits seen on secondary

   // tick clock stands still outside frames; idle frame level is
   // chosen so that the first tick always lands on a frame edge
   always @(posedge sys_clk_in) begin
      if (rst_in || !run_in) begin
         cnt <= 4'h0;
         pos <= 11'h000;
         bit_tick_out <= 1'b0;
         frame_clk_out <= half_in;
         pri_ones <= 0;
         sec_ones <= 0;
         if (rst_in) frames_out <= 8'h00;
      end else begin
         cnt <= (cnt == gap_in - 4'h1) ? 4'h0 : cnt + 4'h1;
         bit_tick_out <= (cnt == 4'h0);
         if (cnt == 4'h0) begin
            // tdm: one-slot frame pulse; halves: low left, high right
            frame_clk_out <= half_in ? pos[10] : (pos < 11'h020);
            cur <= pos;
            pos <= pos + 11'h001;
         end
         // pins settled two cycles after the tick was taken
         if (cnt == 4'h3) begin
            // a released line reads back inverted, so it cannot pass
            pri_word[cur[10:5]][5'h1F - cur[4:0]] <= pri_in ^ !pri_oe_in;
            sec_word[cur[10:5]][5'h1F - cur[4:0]] <= sec_in ^ !sec_oe_in;
            pri_ones <= pri_ones + int'(pri_oe_in);
            sec_ones <= sec_ones + int'(sec_oe_in);
            if (cur == 11'h7FF) frames_out <= frames_out + 8'h01;
         end
      end
   end
endmodule : csm_host_model
`default_nettype wire

// ==== verification/csm_top_bench.sv ====
/*
 self-checking bench for the slot mapper: axi4-lite register tasks,
 sample pushes and whole frames received by the host model.
 assumes the design answers on the handshakes described at its ports.
*/
`default_nettype none
module csm_top_bench;
   import csm_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_in, rst_in, awvalid_in, awready_out, wvalid_in;
   logic wready_out, bvalid_out, bready_in, arvalid_in, arready_out;
   logic rvalid_out, rready_in, sample_valid_in, sample_ready_out;
   logic tick, fclk, pri, pri_oe, sec, sec_oe, run, half;
   logic [ADDR_W-1:0]   awaddr_in, araddr_in;
   logic [31:0]         wdata_in, rdata_out, v;
   logic [3:0]          wstrb_in, gap;
   logic [1:0]          bresp_out, rresp_out;
   logic [SAMPLE_W-1:0] sample_data_in;
   logic [CHID_W-1:0]   sample_chan_in;
   logic [7:0]          frames, f0;
   int                  fail_count, samples_checked;

   csm_top uut (.sys_clk_in, .rst_in, .awaddr_in, .awvalid_in,
      .awready_out, .wdata_in, .wstrb_in, .wvalid_in, .wready_out,
      .bresp_out, .bvalid_out, .bready_in, .araddr_in, .arvalid_in,
      .arready_out, .rdata_out, .rresp_out, .rvalid_out, .rready_in,
      .sample_data_in, .sample_chan_in, .sample_valid_in,
      .sample_ready_out, .bit_tick_in(tick), .frame_clk_in(fclk),
      .primary_serial_out_pin_out(pri),
      .primary_serial_out_pin_oe_out(pri_oe),
      .general_pin_one_out(sec), .general_pin_one_oe_out(sec_oe));

   csm_host_model host (.sys_clk_in, .rst_in, .run_in(run),
      .half_in(half), .gap_in(gap), .pri_in(pri), .pri_oe_in(pri_oe),
      .sec_in(sec), .sec_oe_in(sec_oe), .bit_tick_out(tick),
      .frame_clk_out(fclk), .frames_out(frames));

   // 100 mhz system clock
   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run;
      if (fail_count == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run

   // write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                     input logic [1:0] er);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge sys_clk_in);
      awaddr_in <= ADDR_W'({idx, 2'b00});
      wdata_in <= d;
      awvalid_in <= 1'b1;
      wvalid_in <= 1'b1;
      bready_in <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge sys_clk_in);
         if (!aw_ok && awready_out === 1'b1) begin
            awvalid_in <= 1'b0;
            aw_ok = 1'b1;
         end
         if (!w_ok && wready_out === 1'b1) begin
            wvalid_in <= 1'b0;
            w_ok = 1'b1;
         end
      end
      do @(posedge sys_clk_in); while (bvalid_out !== 1'b1);
      bready_in <= 1'b0;
      check(32'(bresp_out), 32'(er));
   endtask : wr

   // read: rready held until rvalid is seen, response checked
   task automatic rd(input logic [7:0] idx, output logic [31:0] d,
                     input logic [1:0] er);
      @(posedge sys_clk_in);
      araddr_in <= ADDR_W'({idx, 2'b00});
      arvalid_in <= 1'b1;
      rready_in <= 1'b1;
      do @(posedge sys_clk_in); while (arready_out !== 1'b1);
      arvalid_in <= 1'b0;
      do @(posedge sys_clk_in); while (rvalid_out !== 1'b1);
      rready_in <= 1'b0;
      d = rdata_out;
      check(32'(rresp_out), 32'(er));
   endtask : rd

   task automatic push(input logic [1:0] ch, input logic [31:0] d);
      @(posedge sys_clk_in);
      sample_chan_in <= ch;
      sample_data_in <= d;
      sample_valid_in <= 1'b1;
      do @(posedge sys_clk_in); while (sample_ready_out !== 1'b1);
      sample_valid_in <= 1'b0;
   endtask : push

   // one full frame: each channel's word must land on its line and slot
   task automatic frame(input logic [7:0] ctl, input logic [7:0] c3,
                        input logic [7:0] c4, input logic [7:0] c5);
      logic [7:0] cfg [3];
      int np;
      cfg = '{c3, c4, c5};
      np = 0;
      half <= ctl[1];
      for (int i = 0; i < 3; i++) begin
         wr(IDX_CHAN3 + 8'(i), 32'(cfg[i]), RESP_OKAY);
         push(2'(i), 32'hA5C30F10 + 32'(i));
         np += int'(cfg[i][6] == 1'b0);
      end
      wr(IDX_CTRL, 32'(ctl), RESP_OKAY);
      f0 = frames;
      run <= 1'b1;
      wait (frames != f0);
      for (int i = 0; i < 3; i++) begin
         v = cfg[i][6] ? host.sec_word[cfg[i][5:0]]
                       : host.pri_word[cfg[i][5:0]];
         check(v, 32'hA5C30F10 + 32'(i));
      end
      check(32'(host.pri_ones), 32'(np * 32));
      check(32'(host.sec_ones), 32'((3 - np) * 32));
      run <= 1'b0;
      wr(IDX_CTRL, 32'h00000000, RESP_OKAY);
   endtask : frame

   // watchdog well beyond the four frames the run needs
   initial begin
      repeat (90000) @(posedge sys_clk_in);
      fail_count++;
      complete_run();
   end

   initial begin
      {awvalid_in, wvalid_in, bready_in, arvalid_in, rready_in} = 5'h00;
      {sample_valid_in, run, half} = 3'h0;
      awaddr_in = '0;
      araddr_in = '0;
      wdata_in = 32'h00000000;
      wstrb_in = 4'hF;
      sample_data_in = '0;
      sample_chan_in = '0;
      gap = 4'h4;
      rst_in = 1'b1;
      repeat (8) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      // reset values: slot codes 2, 3 and 4, primary line
      for (int i = 0; i < 3; i++) begin
         rd(IDX_CHAN3 + 8'(i), v, RESP_OKAY);
         check(v, 32'h00000002 + 32'(i));
      end
      // bit 7 reserved, bits 6:0 writable
      wr(IDX_CHAN3, 32'h000000FF, RESP_OKAY);
      rd(IDX_CHAN3, v, RESP_OKAY);
      check(v, 32'h0000007F);
      // unmapped place answers with an error and no data
      wr(8'h30, 32'h00000055, RESP_SLVERR);
      rd(8'h30, v, RESP_SLVERR);
      check(v, 32'h00000000);
      // lane 0 strobe off: answered, nothing stored
      wstrb_in <= 4'hE;
      wr(IDX_CHAN3, 32'h00000011, RESP_OKAY);
      wstrb_in <= 4'hF;
      rd(IDX_CHAN3, v, RESP_OKAY);
      check(v, 32'h0000007F);
      push(2'h3, 32'hDEADBEEF);
      frame(8'h01, 8'h00, 8'h61, 8'h3F);
      frame(8'h03, 8'h1F, 8'h20, 8'h42);
      // fill: three holds, then four fifo words until refused
      for (int i = 0; i < 7; i++) push(2'(i % 3), 32'h0F0F0000 + 32'(i));
      @(posedge sys_clk_in);
      check(32'(sample_ready_out), 32'h00000000);
      // drain over two slow frames
      gap <= 4'h6;
      wr(IDX_CTRL, 32'h00000003, RESP_OKAY);
      f0 = frames;
      run <= 1'b1;
      wait (frames == f0 + 8'h02);
      run <= 1'b0;
      rd(IDX_STAT, v, RESP_OKAY);
      // fifo empty, only the third channel's hold refilled
      check(v & 32'h0000000F, 32'h00000002);
      check(32'(sample_ready_out), 32'h00000001);
      complete_run();
   end
endmodule : csm_top_bench
`default_nettype wire
